// ### adcc_serial_cfg.sv
/*
  Serial command decoder and configuration word of the converter.
  Assumes: pins are asynchronous and SCLK is at most i_clock/8; the result
  and fifo level come from converter logic on i_clock.
*/
// Behaviour
// - 16-bit input word, command high, data low
// - non-write commands need only four bits
// - fifo read shifts oldest result, six pad
// - result is straight binary, passed unchanged
// - fs high at cs fall: rise in
// - fs used: fs fall starts, fall in
// - codes 0-7 select inputs; variant halves
// - code 8 powers down analog and reference
// - code 9 returns config in low bits
// - code 10 loads twelve bits into config
// - codes 11-13 select test voltages
// - config survives power down states
// - write survives a pause in sclk
// - bit 11 reference source, bit 10 level
// - bit 9 sampling 12 or 24 clocks
// - bits 8-7 conversion clock source
// - bits 6-5 conversion mode
// - bits 4-3 sweep order
// - bit 2 status pin function
// - bits 1-0 fifo threshold level
// - sweep order only in sweep modes
// - result first, sdo released after bit 16
`timescale 1ns/100ps
module adcc_serial_cfg
  import adcc_pkg::*;
#(
  parameter bit EIGHT_INPUT = 1'b1,
  parameter int OSC_CNT = OSC_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire adcc_pins_t i_pins,
  input wire logic [RES_BITS-1:0] i_result,
  input wire logic i_conv_busy,
  input wire logic i_conv_done,
  input wire logic [3:0] i_fifo_level,
  output logic o_sdo,
  output logic o_sdo_oe,
  output adcc_cfg_t o_cfg,
  output logic [2:0] o_channel,
  output adcc_test_t o_test_sel,
  output logic o_sample_start,
  output logic o_power_down,
  output logic o_fifo_pop,
  output logic o_cfg_written,
  output logic o_host_ready,
  output logic [4:0] o_sample_clks,
  output logic o_sweep_en,
  output logic o_conv_clk_en,
  output logic o_status_pin
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  adcc_pins_t s;
  adcc_pins_t rise;
  adcc_pins_t fall;

  // cs_b resets high so no false frame start
  adcc_pin_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_d(i_pins),
    .o_q(s),
    .o_rise(rise),
    .o_fall(fall)
  );

  // ****************************************
  // frame control
  // ****************************************
  adcc_state_t state_q;
  logic dsp_q;
  logic start;
  logic in_edge;
  logic out_edge;

  // a frame begins at cs fall (fs high) or, if fs was low at cs fall, at fs fall while cs is low
  assign start = (state_q != ST_SHIFT || dsp_q) && !s.cs_b &&
                 ((fall.cs_b && s.fs) || (dsp_q && fall.fs));
  assign in_edge = dsp_q ? fall.sclk : rise.sclk;
  assign out_edge = dsp_q ? rise.sclk : fall.sclk;

  // frame state follows chip select; fs mode is latched at cs fall
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      dsp_q <= 1'b0;
    end else if (s.cs_b) begin
      state_q <= ST_IDLE;
      dsp_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fall.cs_b) begin
            dsp_q <= !s.fs;
            state_q <= s.fs ? ST_SHIFT : ST_WAIT_FS;
          end
        end
        ST_WAIT_FS: begin
          if (fall.fs) begin
            state_q <= ST_SHIFT;
          end
        end
        default: begin
          state_q <= ST_SHIFT;
        end
      endcase
    end
  end

  // ****************************************
  // input shifter and command decode
  // ****************************************
  logic [4:0] bit_cnt_q;
  logic [CFG_BITS+2:0] in_sr_q;
  logic [3:0] cmd_q;
  logic [3:0] cmd_next;
  logic [CFG_BITS-1:0] wr_data;
  logic take_bit;
  logic cmd_stb;
  logic wr_stb;

  assign take_bit = state_q == ST_SHIFT && !s.cs_b && in_edge && bit_cnt_q < BIT_FULL;
  assign cmd_next = {in_sr_q[2:0], s.sdi};
  assign wr_data = {in_sr_q[CFG_BITS-2:0], s.sdi};
  assign cmd_stb = take_bit && bit_cnt_q == BIT_DECODE;
  assign wr_stb = take_bit && bit_cnt_q == BIT_LAST && cmd_q == CMD_CFG_WR;

  // msb first; a stalled sclk simply holds the count
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_q <= '0;
      in_sr_q <= '0;
    end else if (start) begin
      bit_cnt_q <= '0;
    end else if (take_bit) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      in_sr_q <= {in_sr_q[CFG_BITS+1:0], s.sdi};
    end
  end

  // command held for the whole frame
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_q <= CMD_RSVD;
    end else if (cmd_stb) begin
      cmd_q <= cmd_next;
    end
  end

  // ****************************************
  // configuration word
  // ****************************************
  adcc_cfg_t cfg_q;

  // only a write command touches it; power down leaves it alone
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= adcc_cfg_t'(CFG_RST);
    end else if (wr_stb) begin
      cfg_q <= adcc_cfg_t'(wr_data);
    end
  end
  assign o_cfg = cfg_q;

  // host interface counts as set up after the first write
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_host_ready <= 1'b0;
      o_cfg_written <= 1'b0;
    end else begin
      o_cfg_written <= wr_stb;
      if (wr_stb) begin
        o_host_ready <= 1'b1;
      end
    end
  end

  // ****************************************
  // command effects
  // ****************************************
  // odd codes 1-7 on the four-input part fall through with no effect
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_channel <= '0;
      o_test_sel <= TST_NONE;
      o_sample_start <= 1'b0;
      o_power_down <= 1'b0;
      o_fifo_pop <= 1'b0;
    end else begin
      o_sample_start <= 1'b0;
      o_power_down <= 1'b0;
      o_fifo_pop <= 1'b0;
      if (cmd_stb) begin
        if (!cmd_next[3]) begin
          if (EIGHT_INPUT) begin
            o_channel <= cmd_next[2:0];
            o_test_sel <= TST_NONE;
            o_sample_start <= 1'b1;
          end else if (!cmd_next[0]) begin
            o_channel <= {1'b0, cmd_next[2:1]};
            o_test_sel <= TST_NONE;
            o_sample_start <= 1'b1;
          end
        end else if (cmd_next == CMD_TST_MID) begin
          o_test_sel <= TST_MID;
          o_sample_start <= 1'b1;
        end else if (cmd_next == CMD_TST_LO) begin
          o_test_sel <= TST_LO;
          o_sample_start <= 1'b1;
        end else if (cmd_next == CMD_TST_HI) begin
          o_test_sel <= TST_HI;
          o_sample_start <= 1'b1;
        end else if (cmd_next == CMD_PWR_DN) begin
          o_power_down <= 1'b1;
        end else if (cmd_next == CMD_FIFO_RD) begin
          o_fifo_pop <= 1'b1;
        end
        // reserved code deliberately lands nowhere
      end
    end
  end

  // ****************************************
  // output word
  // ****************************************
  logic [WORD_BITS-1:0] out_word_q;
  logic [3:0] out_idx_q;
  logic out_done_q;

  // result loads at frame start; config read overwrites the low twelve
  // bits before bit 11 is shown, since bit 11 leaves on the 4th out edge
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_word_q <= '0;
      out_idx_q <= 4'hf;
      out_done_q <= 1'b1;
    end else if (start) begin
      out_word_q <= {i_result, {PAD_BITS{1'b0}}};
      out_idx_q <= 4'hf;
      out_done_q <= 1'b0;
    end else begin
      if (cmd_stb && cmd_next == CMD_CFG_RD) begin
        out_word_q[CFG_BITS-1:0] <= cfg_q;
      end
      if (state_q == ST_SHIFT && out_edge && bit_cnt_q != '0 && !out_done_q) begin
        if (out_idx_q == '0) begin
          out_done_q <= 1'b1;
        end else begin
          out_idx_q <= out_idx_q - 4'h1;
        end
      end
    end
  end
  assign o_sdo = out_word_q[out_idx_q];
  assign o_sdo_oe = state_q == ST_SHIFT && !s.cs_b && !out_done_q;

  // ****************************************
  // configuration decodes
  // ****************************************
  logic [3:0] thr_lvl;
  logic thr_hit;
  logic thr_hit_q;
  logic int_q;

  always_comb begin
    case (cfg_q.thresh)
      2'h0: thr_lvl = THR_FULL;
      2'h1: thr_lvl = THR_3Q;
      2'h2: thr_lvl = THR_HALF;
      default: thr_lvl = THR_1Q;
    endcase
  end
  assign thr_hit = i_fifo_level >= thr_lvl;

  // sampling length and sweep gating
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sample_clks <= SAMP_SHORT;
      o_sweep_en <= 1'b0;
    end else begin
      o_sample_clks <= cfg_q.long_samp ? SAMP_LONG : SAMP_SHORT;
      o_sweep_en <= cfg_q.mode == M_SWEEP || cfg_q.mode == M_RSWEEP;
    end
  end

  // interrupt: set wins over the clear at a new frame
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr_hit_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      thr_hit_q <= thr_hit;
      if ((cfg_q.mode == M_SINGLE && i_conv_done) ||
          (cfg_q.mode != M_SINGLE && thr_hit && !thr_hit_q)) begin
        int_q <= 1'b1;
      end else if (start) begin
        int_q <= 1'b0;
      end
    end
  end

  // shared pin, active low in both uses
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_pin <= 1'b1;
    end else begin
      o_status_pin <= cfg_q.eoc_pin ? !i_conv_busy : !int_q;
    end
  end

  // ****************************************
  // conversion clock enable
  // ****************************************
  // sclk-based sources stop when the host stops sclk: a known limitation
  logic [7:0] osc_cnt_q;
  logic [1:0] sclk_cnt_q;
  logic osc_tick;

  assign osc_tick = osc_cnt_q == 8'(OSC_CNT - 1);

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_cnt_q <= '0;
      sclk_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_tick ? 8'h00 : osc_cnt_q + 8'h01;
      if (rise.sclk) begin
        sclk_cnt_q <= sclk_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_conv_clk_en <= 1'b0;
    end else begin
      case (cfg_q.clk_src)
        CLK_OSC: o_conv_clk_en <= osc_tick;
        CLK_SCLK: o_conv_clk_en <= rise.sclk;
        CLK_DIV4: o_conv_clk_en <= rise.sclk && sclk_cnt_q == SCLK_DIV4_LAST;
        default: o_conv_clk_en <= rise.sclk && sclk_cnt_q[0];
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  a_cfg_write_load: assert property (wr_stb |=> cfg_q == $past(wr_data))
    else $error("config write not loaded");
  a_cfg_hold: assert property (!wr_stb |=> $stable(cfg_q))
    else $error("config changed without write");
  a_cmd_decode: assert property (cmd_stb |=> cmd_q == $past(cmd_next))
    else $error("command not decoded at fourth bit");
  a_cfg_read: assert property (cmd_stb && cmd_next == CMD_CFG_RD
      |=> out_word_q[CFG_BITS-1:0] == cfg_q)
    else $error("config not placed in output word");
  a_result_top: assert property (start |=> out_word_q[WORD_BITS-1:PAD_BITS] == $past(i_result))
    else $error("result not loaded in top bits");
  a_sdo_release: assert property (out_done_q |-> !o_sdo_oe)
    else $error("sdo driven after sixteenth bit");
  a_pwr_pulse: assert property (cmd_stb && cmd_next == CMD_PWR_DN
      |=> o_power_down ##1 !o_power_down)
    else $error("power down pulse wrong");
  a_rsvd_quiet: assert property (cmd_stb && cmd_next == CMD_RSVD
      |=> !o_sample_start && !o_power_down && !o_fifo_pop && $stable(o_channel))
    else $error("reserved code had an effect");
  a_chan_sel: assert property (cmd_stb && !cmd_next[3] && EIGHT_INPUT
      |=> o_channel == $past(cmd_next[2:0]) && o_sample_start)
    else $error("channel not selected");
  a_spi_edge: assert property (state_q == ST_SHIFT && !dsp_q && fall.sclk |-> !take_bit)
    else $error("input taken on wrong edge");

  c_cfg_write: cover property (wr_stb);
  c_cfg_read: cover property (cmd_stb && cmd_next == CMD_CFG_RD);
  c_dsp_frame: cover property (start && dsp_q);
  c_fifo_read: cover property (o_fifo_pop);

endmodule

// ### adcc_pkg.sv
/*
  Shared constants and types for the serial command and configuration block
  of a multi-input 10-bit converter.
  Assumes: a single 100 MHz system clock; serial pins arrive asynchronously.
*/
package adcc_pkg;

  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int CMD_BITS = 4;
  localparam int CFG_BITS = 12;
  localparam int RES_BITS = 10;
  localparam int PAD_BITS = WORD_BITS - RES_BITS;
  localparam logic [4:0] BIT_DECODE = 5'h03; // input count before the 4th bit
  localparam logic [4:0] BIT_LAST = 5'h0f;   // input count before the 16th bit
  localparam logic [4:0] BIT_FULL = 5'h10;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [3:0] CMD_PWR_DN = 4'h8;
  localparam logic [3:0] CMD_CFG_RD = 4'h9;
  localparam logic [3:0] CMD_CFG_WR = 4'ha;
  localparam logic [3:0] CMD_TST_MID = 4'hb;
  localparam logic [3:0] CMD_TST_LO = 4'hc;
  localparam logic [3:0] CMD_TST_HI = 4'hd;
  localparam logic [3:0] CMD_FIFO_RD = 4'he;
  localparam logic [3:0] CMD_RSVD = 4'hf;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam logic [4:0] SAMP_SHORT = 5'h0c;
  localparam logic [4:0] SAMP_LONG = 5'h18;
  localparam logic [3:0] THR_FULL = 4'h8;
  localparam logic [3:0] THR_3Q = 4'h6;
  localparam logic [3:0] THR_HALF = 4'h4;
  localparam logic [3:0] THR_1Q = 4'h2;
  localparam logic [1:0] SCLK_DIV4_LAST = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 50;
  localparam int OSC_DIV = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {CLK_OSC, CLK_SCLK, CLK_DIV4, CLK_DIV2} adcc_clk_src_t;
  typedef enum logic [1:0] {M_SINGLE, M_REPEAT, M_SWEEP, M_RSWEEP} adcc_mode_t;
  typedef enum logic [1:0] {TST_NONE, TST_MID, TST_LO, TST_HI} adcc_test_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FS, ST_SHIFT} adcc_state_t;

  typedef struct packed {
    logic ref_int;
    logic ref_2v;
    logic long_samp;
    adcc_clk_src_t clk_src;
    adcc_mode_t mode;
    logic [1:0] sweep;
    logic eoc_pin;
    logic [1:0] thresh;
  } adcc_cfg_t;

  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic sdi;
    logic fs;
  } adcc_pins_t;

endpackage

// ### adcc_pin_sync.sv
/*
  Two-stage synchroniser with edge detection for a group of pins.
  Assumes: pins change slowly against i_clock (at least four clocks per level).
*/
`timescale 1ns/100ps
module adcc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges seen on the settled copy only
  assign o_q = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;

endmodule

// ### adcc_host_model.sv
/*
  Host model: serial master that frames 16-bit words into the command block.
  Assumes: i_clock at 100 MHz; the block samples pins through synchronisers.
*/
`timescale 1ns/100ps
module adcc_host_model
  import adcc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output adcc_pins_t o_pins
);
  // ****************************************
  // frame driver
  // ****************************************
  localparam int HALF = 10; // sclk half period in clocks, above the 4 minimum

  // idle levels: deselected, clock parked low
  initial begin
    o_pins = '{cs_b: 1'b1, sclk: 1'b0, sdi: 1'b0, fs: 1'b1};
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // one word msb first; dsp picks strobe framing, pause stalls after 8 bits
  task automatic frame(input logic [15:0] w, input bit dsp, input bit pause,
                       output logic [15:0] rd);
    rd = '0;
    @(posedge i_clock);
    o_pins.fs <= ~dsp;
    wait_clk(2);
    o_pins.cs_b <= 1'b0;
    if (dsp) begin
      wait_clk(HALF);
      o_pins.fs <= 1'b1;
      wait_clk(HALF);
      o_pins.fs <= 1'b0;
    end
    wait_clk(HALF);
    for (int i = 15; i >= 0; i--) begin
      if (pause && i == 7) wait_clk(20 * HALF);
      o_pins.sclk <= dsp;
      o_pins.sdi <= w[i];
      wait_clk(HALF);
      o_pins.sclk <= ~dsp;
      rd[i] = i_sdo_oe ? i_sdo : 1'bx; // an undriven bit must never match
      wait_clk(HALF);
    end
    // one more output edge lets the block release sdo
    o_pins.sclk <= dsp;
    wait_clk(HALF);
    o_pins.sclk <= 1'b0;
    wait_clk(HALF);
    o_pins.cs_b <= 1'b1;
    o_pins.sdi <= ~w[0]; // released line does not keep its last bit
    wait_clk(6);
  endtask
endmodule

// ### testbench.sv
/*
  Testbench for the serial command and configuration block.
  Assumes: the host model drives the pins; converter inputs are driven here.
*/
`timescale 1ns/100ps
module testbench;
  import adcc_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam int OSC_SIM = 2; // short oscillator divide keeps the run brief
  logic i_clock;
  logic i_rst_b;
  adcc_pins_t pins;
  logic [RES_BITS-1:0] result;
  logic conv_busy;
  logic conv_done;
  logic [3:0] fifo_level;
  logic sdo, sdo_oe, sample_start, power_down, fifo_pop, cfg_written;
  logic host_ready, sweep_en, conv_clk_en, status_pin;
  adcc_cfg_t cfg;
  logic [2:0] channel;
  logic [2:0] channel4;
  logic [2:0] e4 = 3'h0;
  adcc_test_t test_sel;
  logic [4:0] sample_clks;
  logic [15:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int n_start = 0, n_pd = 0, n_pop = 0, n_wr = 0, n_clk = 0, s = 0, p = 0;
  logic [11:0] cfg_tab [5] = '{12'h2a9, 12'hc00, 12'h1d6, 12'h3ff, 12'h804};
  logic [3:0] thr_tab [4] = '{THR_FULL, THR_3Q, THR_HALF, THR_1Q};

  adcc_serial_cfg #(.EIGHT_INPUT(1'b1), .OSC_CNT(OSC_SIM)) i_adcc_serial_cfg (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(pins), .i_result(result),
    .i_conv_busy(conv_busy), .i_conv_done(conv_done), .i_fifo_level(fifo_level),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_cfg(cfg), .o_channel(channel), .o_test_sel(test_sel),
    .o_sample_start(sample_start), .o_power_down(power_down), .o_fifo_pop(fifo_pop),
    .o_cfg_written(cfg_written), .o_host_ready(host_ready), .o_sample_clks(sample_clks),
    .o_sweep_en(sweep_en), .o_conv_clk_en(conv_clk_en), .o_status_pin(status_pin));
  // four-input variant shares the pins; only its channel map is watched
  adcc_serial_cfg #(.EIGHT_INPUT(1'b0), .OSC_CNT(OSC_SIM)) i_adcc_serial_cfg_four (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(pins), .i_result(result),
    .i_conv_busy(conv_busy), .i_conv_done(conv_done), .i_fifo_level(fifo_level),
    .o_sdo(), .o_sdo_oe(), .o_cfg(), .o_channel(channel4), .o_test_sel(),
    .o_sample_start(), .o_power_down(), .o_fifo_pop(), .o_cfg_written(),
    .o_host_ready(), .o_sample_clks(), .o_sweep_en(), .o_conv_clk_en(), .o_status_pin());
  adcc_host_model i_adcc_host_model (.i_clock(i_clock), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
    .o_pins(pins));

  // ****************************************
  // clock, pulse counters, watchdog
  // ****************************************
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // pulses stand one cycle, so count them rather than poll
  always @(posedge i_clock) begin
    n_start += (sample_start === 1'b1);
    n_pd += (power_down === 1'b1);
    n_pop += (fifo_pop === 1'b1);
    n_wr += (cfg_written === 1'b1);
    n_clk += (conv_clk_en === 1'b1);
  end

  initial begin
    repeat (90000) @(posedge i_clock);
    err_total++;
    close_out();
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic [15:0] w, input bit dsp = 1'b0, input bit pause = 1'b0);
    i_adcc_host_model.frame(w, dsp, pause, rd);
  endtask

  // bounded wait for the status pin, then compare
  task automatic expect_status(input logic v);
    for (int k = 0; k < 20 && status_pin !== v; k++) @(posedge i_clock);
    check("status_pin", status_pin, v);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_rst_b = 1'b0;
    result = 10'h000;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    fifo_level = 4'h0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    check("cfg", cfg, CFG_RST);
    check("sample_clks", sample_clks, SAMP_SHORT);
    check("host_ready", host_ready, 1'b0);
    check("sdo_oe", sdo_oe, 1'b0);
    xfer({CMD_CFG_WR, 12'h000});
    check("host_ready", host_ready, 1'b1);
    check("cfg_written", n_wr, 1);
    // every field, both framings, stalls mid-word
    for (int i = 0; i < 5; i++) begin
      xfer({CMD_CFG_WR, cfg_tab[i]}, i[0], i == 2 || i == 3);
      check("cfg", cfg, cfg_tab[i]);
      check("sample_clks", sample_clks, cfg_tab[i][9] ? SAMP_LONG : SAMP_SHORT);
      check("sweep_en", sweep_en, cfg_tab[i][6]);
      if (cfg_tab[i][6:5] == 2'b00) begin
        xfer({CMD_CFG_RD, 12'h000}, i[0]);
        check("cfg_read", rd[11:0], cfg_tab[i]);
        check("sdo_oe", sdo_oe, 1'b0);
      end
    end
    s = n_pd;
    xfer({CMD_PWR_DN, 12'h000}, 1'b1);
    check("power_down", n_pd - s, 1);
    check("cfg", cfg, 12'h804);
    conv_busy <= 1'b1;
    expect_status(1'b0);
    conv_busy <= 1'b0;
    expect_status(1'b1);
    s = n_clk;
    repeat (100) @(posedge i_clock);
    p = n_clk - s;
    check("conv_clk_en", p >= 100 / OSC_SIM - 1 && p <= 100 / OSC_SIM + 1, 1'b1);
    // sclk and sclk/4 sources: one frame gives sixteen rises
    xfer({CMD_CFG_WR, 12'h080});
    s = n_clk;
    xfer({CMD_CFG_RD, 12'h000});
    check("conv_clk_sclk", n_clk - s, 16);
    xfer({CMD_CFG_WR, 12'h100});
    s = n_clk;
    xfer({CMD_CFG_RD, 12'h000});
    check("conv_clk_div4", n_clk - s, 4);
    check("cfg_read", rd[11:0], 12'h100);
    for (int t = 1; t < 4; t++) begin
      s = n_start;
      xfer({CMD_TST_MID + t[3:0] - 4'h1, 12'h000}, t[0]);
      check("test_sel", test_sel, t[1:0]);
      check("sample_start", n_start - s, 1);
    end
    for (int c = 0; c < 8; c++) begin
      result <= 10'h3ff >> c;
      s = n_start;
      xfer({c[3:0], 12'h000}, c[1]);
      if (!c[0]) e4 = c[2:1];
      check("channel", channel, c[2:0]);
      check("channel_four", channel4, e4);
      check("sample_start", n_start - s, 1);
      check("result", rd[15:6], 10'h3ff >> c);
      check("pad", rd[5:0], 6'h00);
    end
    result <= 10'h155;
    s = n_pop;
    xfer({CMD_FIFO_RD, 12'h000}, 1'b1);
    check("fifo_pop", n_pop - s, 1);
    check("fifo_word", rd[15:6], 10'h155);
    // sweep mode: the latch rises when the level reaches the threshold
    for (int t = 0; t < 4; t++) begin
      xfer({CMD_CFG_WR, 12'h040 | t[11:0]});
      fifo_level <= thr_tab[t] - 4'h1;
      repeat (6) @(posedge i_clock);
      check("status_pin", status_pin, 1'b1);
      fifo_level <= thr_tab[t];
      expect_status(1'b0);
      fifo_level <= 4'h0;
    end
    xfer({CMD_CFG_WR, 12'h000});
    conv_done <= 1'b1;
    @(posedge i_clock);
    conv_done <= 1'b0;
    expect_status(1'b0);
    s = n_start + n_pd + n_pop;
    p = n_wr;
    xfer({CMD_RSVD, 12'hfff}, 1'b1);
    check("cfg", cfg, 12'h000);
    check("channel", channel, 3'h7);
    check("pulses", n_start + n_pd + n_pop - s, 0);
    check("cfg_written", n_wr - p, 0);
    expect_status(1'b1);
    close_out();
  end
endmodule
